// ===== logic/spg_pkg.sv
package spg_pkg;

  localparam int unsigned PORT_W = 6;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned SYNC_STAGES = 2;

  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_PORT = 8'h05;
  localparam logic [ADDR_W-1:0] ADDR_PORT_SET = 8'h45;
  localparam logic [ADDR_W-1:0] ADDR_PORT_CLR = 8'h65;
  localparam logic [ADDR_W-1:0] ADDR_INTCTL = 8'h0b;
  localparam logic [ADDR_W-1:0] ADDR_OPTION = 8'h81;
  localparam logic [ADDR_W-1:0] ADDR_DIR = 8'h85;
  localparam logic [ADDR_W-1:0] ADDR_ANSEL = 8'h91;
  localparam logic [ADDR_W-1:0] ADDR_PU = 8'h95;
  localparam logic [ADDR_W-1:0] ADDR_IOC = 8'h96;

  // reset values
  localparam logic [PORT_W-1:0] DIR_RST = 6'h3f;
  localparam logic [PORT_W-1:0] PU_RST = 6'h3f;
  localparam logic [PORT_W-1:0] IOC_RST = 6'h00;
  localparam logic [PORT_W-1:0] LATCH_RST = 6'h00;
  localparam logic [PORT_W-1:0] SNAP_RST = 6'h00;
  localparam logic [DATA_W-1:0] OPTION_RST = 8'hff;
  localparam logic [DATA_W-1:0] ANSEL_RST = 8'hff;

  // field positions and masks
  localparam int unsigned PIN_MASTER_CLEAR_INPUT = 3;
  localparam int unsigned PIN_VREF = 1;
  localparam int unsigned OPT_PULLUP_OFF = 7;
  localparam int unsigned FLAG_BIT = 0;
  localparam logic [PORT_W-1:0] MASTER_CLEAR_INPUT_MASK = 6'h08;
  localparam logic [PORT_W-1:0] VREF_MASK = 6'h02;
  localparam logic [PORT_W-1:0] OSC_MASK = 6'h30;

  typedef enum logic [3:0] {
    SPG_SEL_NONE,
    SPG_SEL_PORT,
    SPG_SEL_PORT_SET,
    SPG_SEL_PORT_CLR,
    SPG_SEL_INTCTL,
    SPG_SEL_OPTION,
    SPG_SEL_DIR,
    SPG_SEL_ANSEL,
    SPG_SEL_PU,
    SPG_SEL_IOC
  } spg_reg_sel_t;

  typedef struct packed {
    logic master_clear_select;
    logic crystal_mode;
    logic vref_out_sel;
  } spg_cfg_t;

  typedef struct packed {
    logic [PORT_W-1:0] out;
    logic [PORT_W-1:0] oe;
    logic [PORT_W-1:0] pullup_on;
  } spg_pin_drive_t;

endpackage : spg_pkg

// ===== logic/spg_sync.sv
`timescale 1ns/1ps
module spg_sync #(
  parameter int unsigned W = 6,
  parameter int unsigned STAGES = 2
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  if (STAGES < 2) begin : g_bad_stages
    $error("spg_sync needs at least two stages");
  end

  // the first stage feeds only the next stage; each stage has its own register
  generate
    for (genvar s = 0; s < STAGES; s++) begin : g_stage
      logic [W-1:0] stage_q;
      if (s == 0) begin : g_first
        always_ff @(posedge core_clk or negedge resetn) begin
          if (!resetn) begin
            stage_q <= '0;
          end else if (ce) begin
            stage_q <= d;
          end
        end
      end else begin : g_next
        always_ff @(posedge core_clk or negedge resetn) begin
          if (!resetn) begin
            stage_q <= '0;
          end else if (ce) begin
            stage_q <= g_stage[s-1].stage_q;
          end
        end
      end
    end
  endgenerate

  assign q = g_stage[STAGES-1].stage_q;

endmodule : spg_sync

// ===== logic/spg_port.sv
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module spg_port #(
  parameter int unsigned PORT_W = 6
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic warm_rst,
  input wire logic [spg_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [spg_pkg::DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [spg_pkg::DATA_W-1:0] bus_rdata,
  input wire spg_pkg::spg_cfg_t cfg,
  input wire logic [PORT_W-1:0] pin_in,
  output spg_pkg::spg_pin_drive_t pin_drv,
  output logic port_change_flag,
  output logic wake_req
);

  if (PORT_W != spg_pkg::PORT_W) begin : g_bad_width
    $error("spg_port supports only the six-pin port");
  end

  function automatic spg_pkg::spg_reg_sel_t reg_sel(input logic [spg_pkg::ADDR_W-1:0] a);
    case (a)
      spg_pkg::ADDR_PORT: reg_sel = spg_pkg::SPG_SEL_PORT;
      spg_pkg::ADDR_PORT_SET: reg_sel = spg_pkg::SPG_SEL_PORT_SET;
      spg_pkg::ADDR_PORT_CLR: reg_sel = spg_pkg::SPG_SEL_PORT_CLR;
      spg_pkg::ADDR_INTCTL: reg_sel = spg_pkg::SPG_SEL_INTCTL;
      spg_pkg::ADDR_OPTION: reg_sel = spg_pkg::SPG_SEL_OPTION;
      spg_pkg::ADDR_DIR: reg_sel = spg_pkg::SPG_SEL_DIR;
      spg_pkg::ADDR_ANSEL: reg_sel = spg_pkg::SPG_SEL_ANSEL;
      spg_pkg::ADDR_PU: reg_sel = spg_pkg::SPG_SEL_PU;
      spg_pkg::ADDR_IOC: reg_sel = spg_pkg::SPG_SEL_IOC;
      default: reg_sel = spg_pkg::SPG_SEL_NONE;
    endcase
  endfunction : reg_sel

  logic [PORT_W-1:0] pins_s;
  logic [PORT_W-1:0] dir_q;
  logic [PORT_W-1:0] pu_q;
  logic [PORT_W-1:0] ioc_q;
  logic [PORT_W-1:0] latch_q;
  logic [PORT_W-1:0] latch_d;
  logic [PORT_W-1:0] snap_q;
  logic [spg_pkg::DATA_W-1:0] option_q;
  logic [spg_pkg::DATA_W-1:0] ansel_q;
  logic flag_q;
  logic [spg_pkg::DATA_W-1:0] rdata_q;
  logic [spg_pkg::DATA_W-1:0] rdata_d;
  spg_pkg::spg_reg_sel_t wr_sel;
  spg_pkg::spg_reg_sel_t rd_sel;
  logic bus_live;
  logic port_access;
  logic [PORT_W-1:0] force_ones;
  logic [PORT_W-1:0] dir_eff;
  logic [PORT_W-1:0] pu_eff;
  logic [PORT_W-1:0] ioc_eff;
  logic [PORT_W-1:0] port_view;
  logic [PORT_W-1:0] mism;
  logic flag_set;
  logic flag_clr;

  // pins are asynchronous to the core clock
  spg_sync #(
    .W(PORT_W),
    .STAGES(spg_pkg::SYNC_STAGES)
  ) u_pin_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .ce(ce),
    .d(pin_in),
    .q(pins_s)
  );

  // a warm reset holds the bus off so the snapshot cannot move under it
  assign bus_live = ce && !warm_rst;
  assign wr_sel = (bus_live && bus_wr) ? reg_sel(bus_addr) : spg_pkg::SPG_SEL_NONE;
  assign rd_sel = (bus_live && bus_rd) ? reg_sel(bus_addr) : spg_pkg::SPG_SEL_NONE;

  // forced-one bits: pin three always in the direction only, oscillator pins in crystal modes
  assign force_ones = spg_pkg::MASTER_CLEAR_INPUT_MASK;
  assign dir_eff = dir_q | force_ones | (cfg.crystal_mode ? spg_pkg::OSC_MASK : '0);
  assign pu_eff = pu_q | (cfg.crystal_mode ? spg_pkg::OSC_MASK : '0);
  assign ioc_eff = ioc_q | (cfg.crystal_mode ? spg_pkg::OSC_MASK : '0);

  // pin levels as software sees them
  always_comb begin
    port_view = pins_s & ~ansel_q[PORT_W-1:0];
    if (cfg.master_clear_select) begin
      port_view[spg_pkg::PIN_MASTER_CLEAR_INPUT] = 1'b0;
    end
  end

  // write-only port aliases let software change one bit without a read first
  always_comb begin
    case (wr_sel)
      spg_pkg::SPG_SEL_PORT: latch_d = bus_wdata[PORT_W-1:0];
      spg_pkg::SPG_SEL_PORT_SET: latch_d = port_view | bus_wdata[PORT_W-1:0];
      spg_pkg::SPG_SEL_PORT_CLR: latch_d = port_view & ~bus_wdata[PORT_W-1:0];
      default: latch_d = latch_q;
    endcase
  end

  // latch content is meaningless after power-up; zero keeps simulation clean
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      latch_q <= spg_pkg::LATCH_RST;
    end else if (ce) begin
      latch_q <= latch_d;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dir_q <= spg_pkg::DIR_RST;
      pu_q <= spg_pkg::PU_RST;
      ioc_q <= spg_pkg::IOC_RST;
      option_q <= spg_pkg::OPTION_RST;
      ansel_q <= spg_pkg::ANSEL_RST;
    end else if (ce) begin
      if (warm_rst) begin
        dir_q <= spg_pkg::DIR_RST;
        pu_q <= spg_pkg::PU_RST;
        ioc_q <= spg_pkg::IOC_RST;
        option_q <= spg_pkg::OPTION_RST;
        ansel_q <= spg_pkg::ANSEL_RST;
      end else begin
        case (wr_sel)
          spg_pkg::SPG_SEL_DIR: dir_q <= bus_wdata[PORT_W-1:0];
          spg_pkg::SPG_SEL_PU: pu_q <= bus_wdata[PORT_W-1:0];
          spg_pkg::SPG_SEL_IOC: ioc_q <= bus_wdata[PORT_W-1:0];
          spg_pkg::SPG_SEL_OPTION: option_q <= bus_wdata;
          spg_pkg::SPG_SEL_ANSEL: ansel_q <= bus_wdata;
          default: dir_q <= dir_q;
        endcase
      end
    end
  end

  // pin drivers
  always_comb begin
    pin_drv.out = latch_q;
    pin_drv.oe = ~dir_eff;
    pin_drv.oe[spg_pkg::PIN_VREF] = ~dir_eff[spg_pkg::PIN_VREF] && !cfg.vref_out_sel;
    pin_drv.pullup_on = pu_eff & dir_eff;
    if (option_q[spg_pkg::OPT_PULLUP_OFF]) begin
      pin_drv.pullup_on = '0;
    end
    if (cfg.master_clear_select) begin
      pin_drv.pullup_on[spg_pkg::PIN_MASTER_CLEAR_INPUT] = 1'b1;
    end
  end

  // any port read or write refreshes the snapshot
  assign port_access = (rd_sel == spg_pkg::SPG_SEL_PORT) ||
                       (wr_sel == spg_pkg::SPG_SEL_PORT) ||
                       (wr_sel == spg_pkg::SPG_SEL_PORT_SET) ||
                       (wr_sel == spg_pkg::SPG_SEL_PORT_CLR);

  // snapshot is only cleared by power-on, never by a warm reset
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      snap_q <= spg_pkg::SNAP_RST;
    end else if (ce && port_access) begin
      snap_q <= pins_s;
    end
  end

  assign mism = (pins_s ^ snap_q) & ioc_eff;
  // a change landing in the access cycle goes into the snapshot unseen
  assign flag_set = ce && !warm_rst && (|mism) && !port_access;
  assign flag_clr = (wr_sel == spg_pkg::SPG_SEL_INTCTL) && !bus_wdata[spg_pkg::FLAG_BIT];

  // set wins over clear, so software must end the mismatch first
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      flag_q <= 1'b0;
    end else if (ce) begin
      if (flag_set) begin
        flag_q <= 1'b1;
      end else if (flag_clr || warm_rst) begin
        flag_q <= 1'b0;
      end
    end
  end

  assign port_change_flag = flag_q;
  // wake is the registered flag level, so a new pin change raises it only while the core clock runs with ce high
  assign wake_req = flag_q;

  always_comb begin
    rdata_d = '0;
    case (rd_sel)
      spg_pkg::SPG_SEL_PORT: rdata_d[PORT_W-1:0] = port_view;
      spg_pkg::SPG_SEL_DIR: rdata_d[PORT_W-1:0] = dir_eff;
      spg_pkg::SPG_SEL_PU: rdata_d[PORT_W-1:0] = pu_eff;
      spg_pkg::SPG_SEL_IOC: rdata_d[PORT_W-1:0] = ioc_eff;
      spg_pkg::SPG_SEL_OPTION: rdata_d = option_q;
      spg_pkg::SPG_SEL_ANSEL: rdata_d = ansel_q;
      spg_pkg::SPG_SEL_INTCTL: rdata_d[spg_pkg::FLAG_BIT] = flag_q;
      default: rdata_d = '0;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= '0;
    end else if (ce) begin
      rdata_q <= rdata_d;
    end
  end

  assign bus_rdata = rdata_q;

  sequence port_rd_s;
    rd_sel == spg_pkg::SPG_SEL_PORT;
  endsequence

  sequence mism_seen_s;
    flag_set;
  endsequence

  chk_port_read_view: assert property (
    @(posedge core_clk) disable iff (!resetn)
    port_rd_s |=> bus_rdata == {2'b00, $past(port_view)})
    else $error("port read does not return masked pin levels");

  chk_analog_reads_zero: assert property (
    @(posedge core_clk) disable iff (!resetn)
    port_rd_s ##1 1'b1 |-> (bus_rdata[PORT_W-1:0] & $past(ansel_q[PORT_W-1:0])) == '0)
    else $error("analog pin read as nonzero");

  chk_upper_bits_zero: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (rd_sel inside {spg_pkg::SPG_SEL_PORT, spg_pkg::SPG_SEL_DIR, spg_pkg::SPG_SEL_PU,
                    spg_pkg::SPG_SEL_IOC}) |=> bus_rdata[7:6] == 2'b00)
    else $error("unimplemented bits read nonzero");

  chk_dir_pin3_one: assert property (
    @(posedge core_clk) disable iff (!resetn)
    rd_sel == spg_pkg::SPG_SEL_DIR |=> bus_rdata[spg_pkg::PIN_MASTER_CLEAR_INPUT])
    else $error("pin three direction read as output");

  chk_master_clear_input_read_zero: assert property (
    @(posedge core_clk) disable iff (!resetn)
    rd_sel == spg_pkg::SPG_SEL_PORT && cfg.master_clear_select |=>
    !bus_rdata[spg_pkg::PIN_MASTER_CLEAR_INPUT])
    else $error("master clear pin read as one");

  chk_dir_drives_pin: assert property (
    @(posedge core_clk) disable iff (!resetn)
    wr_sel == spg_pkg::SPG_SEL_DIR && !bus_wdata[0] && !cfg.crystal_mode ##1 !warm_rst
    |-> pin_drv.oe[0] && pin_drv.out[0] == latch_q[0])
    else $error("output direction did not enable driver");

  chk_vref_driver_off: assert property (
    @(posedge core_clk) disable iff (!resetn)
    cfg.vref_out_sel |-> !pin_drv.oe[spg_pkg::PIN_VREF])
    else $error("reference pin driven while reference output selected");

  chk_pullup_output_off: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (pin_drv.oe & pin_drv.pullup_on) == '0)
    else $error("pull-up on a driven pin");

  chk_pullup_global: assert property (
    @(posedge core_clk) disable iff (!resetn)
    option_q[spg_pkg::OPT_PULLUP_OFF] && !cfg.master_clear_select |-> pin_drv.pullup_on == '0)
    else $error("pull-up on while globally disabled");

  chk_master_clear_input_pullup: assert property (
    @(posedge core_clk) disable iff (!resetn)
    cfg.master_clear_select |-> pin_drv.pullup_on[spg_pkg::PIN_MASTER_CLEAR_INPUT])
    else $error("master clear pull-up missing");

  chk_rmw_set: assert property (
    @(posedge core_clk) disable iff (!resetn)
    wr_sel == spg_pkg::SPG_SEL_PORT_SET |=>
    latch_q == ($past(port_view) | $past(bus_wdata[PORT_W-1:0])))
    else $error("set write did not merge sampled pins");

  chk_flag_sets: assert property (
    @(posedge core_clk) disable iff (!resetn)
    mism_seen_s |=> port_change_flag ##0 wake_req)
    else $error("mismatch did not set change flag");

  chk_warm_snapshot: assert property (
    @(posedge core_clk) disable iff (!resetn)
    warm_rst |=> $stable(snap_q))
    else $error("warm reset disturbed the snapshot");

  chk_read_clears_mism: assert property (
    @(posedge core_clk) disable iff (!resetn)
    port_rd_s ##1 $stable(pins_s) |-> mism == '0)
    else $error("port read did not end the mismatch");

  chk_rmw_clr: assert property (
    @(posedge core_clk) disable iff (!resetn)
    wr_sel == spg_pkg::SPG_SEL_PORT_CLR |=>
    latch_q == ($past(port_view) & ~$past(bus_wdata[PORT_W-1:0])))
    else $error("clear write did not merge sampled pins");

  chk_snap_refresh: assert property (
    @(posedge core_clk) disable iff (!resetn)
    port_access |=> snap_q == $past(pins_s))
    else $error("port access did not refresh the snapshot");

  chk_flag_clears: assert property (
    @(posedge core_clk) disable iff (!resetn)
    flag_clr && !flag_set |=> !port_change_flag)
    else $error("change flag did not clear");

  // warm reset must restore the enables but leave the snapshot to the other check
  chk_warm_defaults: assert property (
    @(posedge core_clk) disable iff (!resetn)
    ce && warm_rst |=> dir_q == spg_pkg::DIR_RST && pu_q == spg_pkg::PU_RST &&
    ioc_q == spg_pkg::IOC_RST && !port_change_flag)
    else $error("warm reset left a register changed");

  chk_ce_freeze: assert property (
    @(posedge core_clk) disable iff (!resetn)
    !ce |=> $stable(latch_q) && $stable(dir_q) && $stable(pu_q) && $stable(snap_q))
    else $error("state moved while clock enable was low");

endmodule : spg_port

// ===== bench/spg_board.sv
`timescale 1ns/1ps
module spg_board (
  input wire logic core_clk,
  input wire spg_pkg::spg_pin_drive_t drv,
  input wire logic [5:0] ext_val,
  input wire logic [5:0] ext_en,
  output logic [5:0] pin_level
);
  // a floating pin shows the inverse of its last level, so no settled value can pass by luck
  logic [5:0] last_q = 6'h00;

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (drv.oe[i]) begin
        pin_level[i] = drv.out[i];
      end else if (ext_en[i]) begin
        pin_level[i] = ext_val[i];
      end else if (drv.pullup_on[i]) begin
        pin_level[i] = 1'b1;
      end else begin
        pin_level[i] = ~last_q[i];
      end
    end
  end

  always @(posedge core_clk) begin
    last_q <= pin_level;
  end
endmodule : spg_board

// ===== bench/test_spg_port.sv
`timescale 1ns/1ps
module test_spg_port;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic warm_rst = 1'b0;
  logic ce = 1'b1;
  logic [7:0] bus_addr = 8'h00;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_rdata;
  spg_pkg::spg_cfg_t cfg = '0;
  logic [5:0] pin_in;
  spg_pkg::spg_pin_drive_t pin_drv;
  logic port_change_flag;
  logic wake_req;
  logic [5:0] ext_val = 6'h00;
  logic [5:0] ext_en = 6'h3f;
  logic [7:0] rd_q;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  typedef struct {logic [7:0] a; logic [7:0] d; logic x; logic [7:0] e;} spg_row_t;
  spg_row_t rows [11] = '{
    '{spg_pkg::ADDR_DIR, 8'h00, 1'b0, 8'h08}, '{spg_pkg::ADDR_DIR, 8'hc0, 1'b1, 8'h38},
    '{spg_pkg::ADDR_PU, 8'hc5, 1'b0, 8'h05}, '{spg_pkg::ADDR_PU, 8'h00, 1'b1, 8'h30},
    '{spg_pkg::ADDR_IOC, 8'hff, 1'b0, 8'h3f}, '{spg_pkg::ADDR_IOC, 8'h00, 1'b1, 8'h30},
    '{spg_pkg::ADDR_OPTION, 8'h5a, 1'b0, 8'h5a}, '{spg_pkg::ADDR_OPTION, 8'hff, 1'b0, 8'hff},
    '{spg_pkg::ADDR_ANSEL, 8'ha5, 1'b0, 8'ha5},
    '{8'h10, 8'hff, 1'b0, 8'h00}, '{spg_pkg::ADDR_DIR, 8'h3f, 1'b0, 8'h3f}};

  always #2 core_clk = ~core_clk;

  spg_port #(.PORT_W(6)) DUT (.core_clk(core_clk), .resetn(resetn), .ce(ce),
    .warm_rst(warm_rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .cfg(cfg), .pin_in(pin_in), .pin_drv(pin_drv),
    .port_change_flag(port_change_flag), .wake_req(wake_req));

  spg_board board (.core_clk(core_clk), .drv(pin_drv), .ext_val(ext_val), .ext_en(ext_en),
    .pin_level(pin_in));

  task automatic close_out();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      close_out();
    end
  end

  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk8

  task automatic chk1(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask : chk1

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge core_clk);
    bus_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    #1;
    rd_q = bus_rdata;
  endtask : rd

  task automatic set_cfg(input logic m, input logic x, input logic v);
    @(posedge core_clk);
    cfg <= '{m, x, v};
    #1;
  endtask : set_cfg

  // synchroniser plus flag register need three edges; four gives margin
  task automatic pins(input logic [5:0] v, input logic [5:0] en);
    @(posedge core_clk);
    ext_val <= v;
    ext_en <= en;
    repeat (4) @(posedge core_clk);
    #1;
  endtask : pins

  initial begin
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    rd(spg_pkg::ADDR_DIR); chk8("dir_rst", 8'h3f, rd_q);
    rd(spg_pkg::ADDR_PU); chk8("pu_rst", 8'h3f, rd_q);
    rd(spg_pkg::ADDR_IOC); chk8("ioc_rst", 8'h00, rd_q);
    chk8("pu_gate_rst", 8'h00, {2'b00, pin_drv.pullup_on});
    chk8("oe_rst", 8'h00, {2'b00, pin_drv.oe});
    foreach (rows[i]) begin
      set_cfg(1'b0, rows[i].x, 1'b0);
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk8("reg_row", rows[i].e, rd_q);
    end
    set_cfg(1'b0, 1'b0, 1'b0);
    wr(spg_pkg::ADDR_PU, 8'h3f);
    wr(spg_pkg::ADDR_ANSEL, 8'h00);
    pins(6'h2a, 6'h3f);
    rd(spg_pkg::ADDR_PORT); chk8("port_view", 8'h2a, rd_q);
    set_cfg(1'b1, 1'b0, 1'b0);
    rd(spg_pkg::ADDR_PORT); chk8("port_master_clear_input", 8'h22, rd_q);
    chk8("master_clear_input_pu", 8'h08, {2'b00, pin_drv.pullup_on});
    set_cfg(1'b0, 1'b0, 1'b0);
    // direction is still all inputs here, as an analog pin needs
    wr(spg_pkg::ADDR_ANSEL, 8'h02);
    rd(spg_pkg::ADDR_PORT); chk8("port_analog", 8'h28, rd_q);
    wr(spg_pkg::ADDR_ANSEL, 8'h00);
    wr(spg_pkg::ADDR_PORT_SET, 8'h01); chk8("rmw_set", 8'h2b, {2'b00, pin_drv.out});
    // pins still read 0x2a, so bit 0 of the latch is lost through the pin sample
    wr(spg_pkg::ADDR_PORT_CLR, 8'h20); chk8("rmw_clr", 8'h0a, {2'b00, pin_drv.out});
    wr(spg_pkg::ADDR_PORT, 8'h15); chk8("latch_wr", 8'h15, {2'b00, pin_drv.out});
    pins(6'h08, 6'h08);
    wr(spg_pkg::ADDR_DIR, 8'h00); chk8("oe_out", 8'h37, {2'b00, pin_drv.oe});
    repeat (3) @(posedge core_clk);
    rd(spg_pkg::ADDR_PORT); chk8("port_drive", 8'h1d, rd_q);
    set_cfg(1'b0, 1'b0, 1'b1); chk8("oe_vref", 8'h35, {2'b00, pin_drv.oe});
    rd(spg_pkg::ADDR_DIR); chk8("dir_vref", 8'h08, rd_q);
    set_cfg(1'b0, 1'b0, 1'b0);
    wr(spg_pkg::ADDR_DIR, 8'h3e);
    wr(spg_pkg::ADDR_OPTION, 8'h00);
    wr(spg_pkg::ADDR_PU, 8'h05); chk8("pu_out", 8'h04, {2'b00, pin_drv.pullup_on});
    wr(spg_pkg::ADDR_DIR, 8'h3f); chk8("pu_in", 8'h05, {2'b00, pin_drv.pullup_on});
    wr(spg_pkg::ADDR_OPTION, 8'h80); chk8("pu_glob", 8'h00, {2'b00, pin_drv.pullup_on});
    // a write while the clock enable is low must be lost
    @(posedge core_clk);
    ce <= 1'b0;
    wr(spg_pkg::ADDR_PU, 8'h00);
    @(posedge core_clk);
    ce <= 1'b1;
    rd(spg_pkg::ADDR_PU); chk8("pu_ce", 8'h05, rd_q);
    pins(6'h00, 6'h3f);
    // refresh the snapshot before enabling, else the stale snapshot raises the flag
    rd(spg_pkg::ADDR_PORT);
    wr(spg_pkg::ADDR_IOC, 8'h01);
    pins(6'h04, 6'h3f); chk1("flag_masked", 1'b0, port_change_flag);
    pins(6'h05, 6'h3f); chk1("flag_set", 1'b1, port_change_flag);
    chk1("wake", 1'b1, wake_req);
    rd(spg_pkg::ADDR_INTCTL); chk1("flag_reg", 1'b1, rd_q[0]);
    wr(spg_pkg::ADDR_INTCTL, 8'h00); chk1("flag_hold", 1'b1, port_change_flag);
    rd(spg_pkg::ADDR_PORT);
    wr(spg_pkg::ADDR_INTCTL, 8'h00); chk1("flag_clr", 1'b0, port_change_flag);
    pins(6'h04, 6'h3f); chk1("flag_again", 1'b1, port_change_flag);
    @(posedge core_clk);
    warm_rst <= 1'b1;
    @(posedge core_clk);
    warm_rst <= 1'b0;
    rd(spg_pkg::ADDR_DIR); chk8("dir_warm", 8'h3f, rd_q);
    // the warm reset clears the enables, so turn bit 0 back on to expose the kept snapshot
    wr(spg_pkg::ADDR_IOC, 8'h01);
    repeat (3) @(posedge core_clk);
    #1;
    chk1("flag_warm", 1'b1, port_change_flag);
    close_out();
  end
endmodule : test_spg_port
